// ### dv/can_tx_select_and_accept_ctrl_test.sv
// Self-checking bench for cts_ctrl: APB read/write sequences with expected values.
// Assumes APB answers after a wait state; read data stands at the ready edge.
`timescale 1ns/100ps
`include "cts_regs.svh"
module can_tx_select_and_accept_ctrl_test;
  import cts_pkg::*;
  logic             pclk = 0;
  logic             presetn = 0;
  logic             psel = 0;
  logic             penable = 0;
  logic             pwrite = 0;
  logic             init_acknowledge = 1;
  logic [11:0]      paddr = '0;
  logic [31:0]      pwdata = '0;
  logic [7:0]       window_rdata = 8'h5a;
  cts_tx_event_type tx_event = '0;
  cts_rx_event_type rx_event = '0;
  logic [31:0]      prdata, rd;
  logic [7:0]       window_addr, window_wdata;
  logic [2:0]       window_buffer, tx_empty_flag;
  logic [1:0]       acceptance_mode_field;
  logic             pready, pslverr, window_access, window_write, rx_accept_enable;
  logic             init_request, irq, err, wac;
  int               fail_count = 0;
  int               checked = 0;

  cts_ctrl cts_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_event(tx_event), .rx_event(rx_event),
    .init_acknowledge(init_acknowledge), .window_access(window_access),
    .window_write(window_write), .window_buffer(window_buffer), .window_addr(window_addr),
    .window_wdata(window_wdata), .window_rdata(window_rdata),
    .rx_accept_enable(rx_accept_enable), .acceptance_mode_field(acceptance_mode_field),
    .tx_empty_flag(tx_empty_flag), .init_request(init_request), .irq(irq));

  always #2 pclk = ~pclk;

  task automatic close_out;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // Request held until pready is seen high; data and error taken at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      close_out;
    end
    err = pslverr;
    wac = window_access;
    rd = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask

  task automatic txp(input logic [5:0] v);
    tx_event <= v;
    @(posedge pclk);
    tx_event <= '0;
    @(posedge pclk);
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rdc(`CTS_OFF_TBSEL, 32'h0, "select");
    rdc(`CTS_OFF_TAAK, 32'h0, "abort ack");
    rdc(`CTS_OFF_MODE, 32'h703, "mode");
    wr(`CTS_OFF_TBSEL, 32'h1);
    rdc(`CTS_OFF_TBSEL, 32'h0, "select in init");
    wr(`CTS_OFF_RSVD_WORD, 32'hffff);
    rdc(`CTS_OFF_RSVD_WORD, 32'h0, "reserved");
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      wr(`CTS_OFF_IDAC, {m[1:0], 4'h7});
      rdc(`CTS_OFF_IDAC, m << 4, "acceptance");
      chk("mode field", m, acceptance_mode_field);
      chk("accept", m != 3, rx_accept_enable);
    end
    rx_event <= 4'hd;
    @(posedge pclk);
    rx_event <= '0;
    rdc(`CTS_OFF_IDAC, 32'h30, "closed hit");
    wr(`CTS_OFF_IDAC, 32'h0);
    wr(`CTS_OFF_MODE, 32'h0);
    init_acknowledge <= 0;
    @(posedge pclk);
    wr(`CTS_OFF_IDAC, 32'h20);
    rdc(`CTS_OFF_IDAC, 32'h0, "acceptance locked");
    for (int h = 0; h < 8; h++) begin
      rx_event <= {1'b1, h[2:0]};
      @(posedge pclk);
      rx_event <= '0;
      rdc(`CTS_OFF_IDAC, h, "hit");
    end
    $display("test acceptance done");
    for (int s = 1; s < 8; s++) begin
      wr(`CTS_OFF_TBSEL, s);
      rdc(`CTS_OFF_TBSEL, s & -s, "select low");
      chk("window buffer", s & -s, window_buffer);
    end
    wr(`CTS_OFF_TBSEL, 32'h0);
    apb(1'b0, `CTS_OFF_WINDOW, 32'h0);
    chk("no select err", 1, err);
    chk("no select access", 0, wac);
    wr(`CTS_OFF_MODE, 32'h100);
    apb(1'b0, `CTS_OFF_MODE, 32'h0);
    wr(`CTS_OFF_TBSEL, rd[10:8]);
    rdc(`CTS_OFF_TBSEL, 32'h2, "free buffer");
    rdc(`CTS_OFF_WINDOW, 32'h5a, "window data");
    chk("window ok", 0, err);
    wr(`CTS_OFF_TBSEL, 32'h1);
    apb(1'b0, `CTS_OFF_WINDOW, 32'h0);
    chk("full err", 1, err);
    chk("full access", 0, wac);
    txp(6'h09);
    rdc(`CTS_OFF_TAAK, 32'h1, "aborted");
    apb(1'b0, `CTS_OFF_WINDOW, 32'h0);
    chk("freed err", 0, err);
    wr(`CTS_OFF_MODE, 32'h100);
    rdc(`CTS_OFF_TAAK, 32'h0, "ack cleared");
    txp(6'h04);
    rdc(`CTS_OFF_TAAK, 32'h4, "aborted 2");
    wr(`CTS_OFF_MODE, 32'h1);
    init_acknowledge <= 1;
    @(posedge pclk);
    rdc(`CTS_OFF_TAAK, 32'h0, "ack in init");
    rdc(`CTS_OFF_TBSEL, 32'h0, "select in init");
    $display("test transmit done");
    rdc(`CTS_OFF_INT_STAT, 32'h7, "status");
    chk("irq masked", 0, irq);
    wr(`CTS_OFF_INT_EN, 32'h2);
    chk("irq on", 1, irq);
    wr(`CTS_OFF_INT_CLR, 32'h7);
    rdc(`CTS_OFF_INT_STAT, 32'h0, "status cleared");
    chk("irq off", 0, irq);
    rdc(`CTS_OFF_INT_CLR, 32'h0, "clear reads zero");
    wr(12'h040, 32'hffffffff);
    rdc(12'h040, 32'h0, "unmapped");
    $display("test interrupt done");
    close_out;
  end
endmodule

// ### logic/cts_ctrl.sv
// APB register slave: abort acknowledge, tx buffer select, acceptance control.
// Assumes engine events are synchronous to pclk and one cycle wide.
// What this block does
// - Three abort-acknowledge bits, 1 means aborted on request, 0 not aborted.
// - Abort-acknowledge bit clears when the same buffer's empty flag clears.
// - Abort-acknowledge register held at reset while init requested and acknowledged.
// - Lowest set select bit maps that tx buffer into the window.
// - Select read returns only the lowest set bit, others zero.
// - Window access blocked while selected buffer is full and scheduled.
// - No window access when no tx buffer is selected.
// - Select held in reset in init mode, writable only fully out of init.
// - Acceptance control readable always, writable in init only, hit bits read-only.
// - Mode 00 two 32-bit, 01 four 16-bit, 10 eight 8-bit, 11 closed.
// - Closed filter accepts nothing, foreground receive buffer never reloaded.
// - Hit field gives binary index 0..7 of matching filter.
// - Hit field follows foreground buffer, updated on every shift in.
// - Reserved test bytes read zero, writes ignored.
// - Device sets empty flag when buffer free, software clears to schedule.
`timescale 1ns/100ps
`include "cts_regs.svh"
module cts_ctrl (
  // APB
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Protocol engine
  input  wire cts_pkg::cts_tx_event_type tx_event,
  input  wire cts_pkg::cts_rx_event_type rx_event,
  input  wire logic                 init_acknowledge,
  // Tx buffer window
  output logic                      window_access,
  output logic                      window_write,
  output logic      [2:0]           window_buffer,
  output logic      [7:0]           window_addr,
  output logic      [7:0]           window_wdata,
  input  wire logic [7:0]           window_rdata,
  // Filter and engine control
  output logic                      rx_accept_enable,
  output logic      [1:0]           acceptance_mode_field,
  output logic      [2:0]           tx_empty_flag,
  output logic                      init_request,
  // Interrupt
  output logic                      irq
);
  import cts_pkg::*;

  logic [2:0] abort_ack_bits;
  logic [2:0] tx_buffer_select;
  logic [1:0] filter_mode;
  logic       ack_q;
  logic [2:0] filter_hit_index;
  logic [2:0] int_stat;
  logic [2:0] int_en;
  logic [2:0] sel_low;
  logic       init_mode;
  logic       out_of_init;
  logic       setup;
  logic       wr;
  logic       rd;
  logic       win_hit;
  logic       win_ok;
  logic       sel_full;
  logic [2:0] sw_clear_empty;
  logic [2:0] next_empty;
  logic       block_event;
  cts_mode_type mode;

  assign init_mode   = init_request & init_acknowledge;
  assign out_of_init = ~init_request & ~init_acknowledge;
  // One wait state: read data is registered in the first access cycle,
  // so it already stands in prdata at the edge where pready is seen high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= setup & ~ack_q;
    end
  end

  assign pready  = ack_q;
  assign setup   = psel & penable;
  assign wr      = setup & pwrite & ack_q;
  assign rd      = setup & ~pwrite & ~ack_q;
  assign win_hit = (paddr >= `CTS_OFF_WINDOW) && (paddr < `CTS_OFF_WINDOW_END);

  // Lowest set bit only
  assign sel_low = tx_buffer_select & (~tx_buffer_select + 3'h1);
  assign sel_full = |(sel_low & ~tx_empty_flag);
  assign win_ok = (|sel_low) & ~sel_full;
  assign block_event = win_hit & setup & ack_q & ~win_ok;
  assign pslverr = block_event;

  assign window_access = win_hit & setup & win_ok;
  assign window_write  = pwrite;
  assign window_buffer = sel_low;
  assign window_addr   = paddr[7:0] - 8'(`CTS_OFF_WINDOW);
  assign window_wdata  = pwdata[7:0];

  assign mode = cts_mode_type'(filter_mode);
  assign acceptance_mode_field = filter_mode;
  assign rx_accept_enable = (mode != cts_closed);

  // Software clears empty flags by writing 1s to the mode register bits [10:8]
  assign sw_clear_empty = (wr && paddr == `CTS_OFF_MODE) ? pwdata[10:8] : 3'h0;
  // Set by engine wins over the software clear
  assign next_empty = (tx_empty_flag & ~sw_clear_empty) | tx_event.done;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_empty_flag <= 3'h7;
    end else begin
      tx_empty_flag <= next_empty;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_request <= 1'b1;
    end else if (wr && paddr == `CTS_OFF_MODE) begin
      init_request <= pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abort_ack_bits <= `CTS_RESET_3;
    end else if (init_mode) begin
      abort_ack_bits <= `CTS_RESET_3;
    end else begin
      // Clear follows the empty flag falling; a fresh abort in the same cycle wins
      abort_ack_bits <= (abort_ack_bits & next_empty) | tx_event.aborted;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buffer_select <= `CTS_RESET_3;
    end else if (init_mode) begin
      tx_buffer_select <= `CTS_RESET_3;
    end else if (out_of_init && wr && paddr == `CTS_OFF_TBSEL) begin
      tx_buffer_select <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filter_mode <= `CTS_RESET_FMODE;
    end else if (init_mode && wr && paddr == `CTS_OFF_IDAC) begin
      filter_mode <= pwdata[`CTS_FMODE_MSB:`CTS_FMODE_LSB];
    end
  end

  // Hit index stays with the foreground buffer; closed filter never loads it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filter_hit_index <= `CTS_RESET_3;
    end else if (rx_event.load && rx_accept_enable) begin
      filter_hit_index <= rx_event.hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_en <= 3'h0;
    end else if (wr && paddr == `CTS_OFF_INT_EN) begin
      int_en <= pwdata[2:0];
    end
  end

  logic [2:0] int_set;
  logic [2:0] int_clr;
  always_comb begin
    int_set = 3'h0;
    int_set[`CTS_INT_HIT]   = rx_event.load & rx_accept_enable;
    int_set[`CTS_INT_ABORT] = |tx_event.aborted;
    int_set[`CTS_INT_BLOCK] = block_event;
    int_clr = (wr && paddr == `CTS_OFF_INT_CLR) ? pwdata[2:0] : 3'h0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat <= 3'h0;
    end else begin
      int_stat <= (int_stat & ~int_clr) | int_set;
    end
  end

  assign irq = |(int_stat & int_en);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd) begin
      if (paddr == `CTS_OFF_TAAK) begin
        prdata <= {29'h0, abort_ack_bits};
      end else if (paddr == `CTS_OFF_TBSEL) begin
        prdata <= {29'h0, sel_low};
      end else if (paddr == `CTS_OFF_IDAC) begin
        prdata <= {26'h0, filter_mode, 1'b0, filter_hit_index};
      end else if (paddr == `CTS_OFF_RSVD_WORD) begin
        prdata <= 32'h0;
      end else if (paddr == `CTS_OFF_INT_STAT) begin
        prdata <= {29'h0, int_stat};
      end else if (paddr == `CTS_OFF_INT_EN) begin
        prdata <= {29'h0, int_en};
      end else if (paddr == `CTS_OFF_MODE) begin
        prdata <= {21'h0, tx_empty_flag, 6'h0, init_acknowledge, init_request};
      end else if (win_hit && win_ok) begin
        prdata <= {24'h0, window_rdata};
      end else begin
        prdata <= 32'h0;
      end
    end
  end

  // Bus handshake: one wait state, then exactly one ready cycle
  chk_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held more than one cycle");

  chk_init_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == `CTS_OFF_MODE) |=> init_request == $past(pwdata[0]))
    else $error("init request not written");

  // Abort acknowledge
  chk_taak_init_hold: assert property (@(posedge pclk) disable iff (!presetn)
    init_mode |=> abort_ack_bits == 3'h0)
    else $error("abort ack not held in init");

  chk_taak_set: assert property (@(posedge pclk) disable iff (!presetn)
    ((|tx_event.aborted) && !init_mode)
    |=> ((abort_ack_bits & $past(tx_event.aborted)) == $past(tx_event.aborted)))
    else $error("abort ack not set");

  chk_taak_rise0: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(abort_ack_bits[0]) |-> $past(tx_event.aborted[0]))
    else $error("abort ack 0 set without abort");

  chk_taak_rise1: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(abort_ack_bits[1]) |-> $past(tx_event.aborted[1]))
    else $error("abort ack 1 set without abort");

  chk_taak_rise2: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(abort_ack_bits[2]) |-> $past(tx_event.aborted[2]))
    else $error("abort ack 2 set without abort");

  chk_taak_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && paddr == `CTS_OFF_TAAK) |=> prdata == {29'h0, $past(abort_ack_bits)})
    else $error("abort ack read wrong");

  chk_taak_clear: assert property (@(posedge pclk) disable iff (!presetn)
    ($fell(tx_empty_flag[0]) && !$past(tx_event.aborted[0])) |-> !abort_ack_bits[0])
    else $error("abort ack not cleared");

  chk_taak_clear1: assert property (@(posedge pclk) disable iff (!presetn)
    ($fell(tx_empty_flag[1]) && !$past(tx_event.aborted[1])) |-> !abort_ack_bits[1])
    else $error("abort ack 1 not cleared");

  chk_taak_clear2: assert property (@(posedge pclk) disable iff (!presetn)
    ($fell(tx_empty_flag[2]) && !$past(tx_event.aborted[2])) |-> !abort_ack_bits[2])
    else $error("abort ack 2 not cleared");

  // Buffer select and window
  chk_tbsel_lowest: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot0(sel_low) && ((sel_low & tx_buffer_select) == sel_low))
    else $error("select not lowest bit");

  chk_tbsel_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && paddr == `CTS_OFF_TBSEL) |=> prdata == {29'h0, $past(sel_low)})
    else $error("select read wrong");

  chk_tbsel_init: assert property (@(posedge pclk) disable iff (!presetn)
    init_mode |=> tx_buffer_select == 3'h0)
    else $error("select not held");

  // Half-way in or out of init the select keeps its value
  chk_tbsel_half: assert property (@(posedge pclk) disable iff (!presetn)
    (!out_of_init && !init_mode) |=> $stable(tx_buffer_select))
    else $error("select changed while init pending");

  chk_tbsel_write: assert property (@(posedge pclk) disable iff (!presetn)
    (out_of_init && wr && paddr == `CTS_OFF_TBSEL)
    |=> tx_buffer_select == $past(pwdata[2:0]))
    else $error("select not written");

  chk_window_onehot: assert property (@(posedge pclk) disable iff (!presetn)
    window_access |-> ($onehot(window_buffer) && window_buffer == sel_low))
    else $error("window buffer not lowest select");

  chk_window_none: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_buffer_select == 3'h0) |-> !window_access)
    else $error("window open unselected");

  chk_window_rd_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && win_hit && !win_ok) |=> prdata == 32'h0)
    else $error("blocked window read nonzero");

  chk_window_full: assert property (@(posedge pclk) disable iff (!presetn)
    sel_full |-> !window_access)
    else $error("window open while full");

  chk_block_err: assert property (@(posedge pclk) disable iff (!presetn)
    (win_hit && setup && ack_q && !win_ok) |-> pslverr)
    else $error("blocked access without error");

  // Empty flags: engine set wins over software clear
  chk_empty_set: assert property (@(posedge pclk) disable iff (!presetn)
    (|tx_event.done) |=> ((tx_empty_flag & $past(tx_event.done)) == $past(tx_event.done)))
    else $error("empty flag not set");

  chk_empty_clear0: assert property (@(posedge pclk) disable iff (!presetn)
    (sw_clear_empty[0] && !tx_event.done[0]) |=> !tx_empty_flag[0])
    else $error("empty flag 0 not cleared");

  chk_empty_clear1: assert property (@(posedge pclk) disable iff (!presetn)
    (sw_clear_empty[1] && !tx_event.done[1]) |=> !tx_empty_flag[1])
    else $error("empty flag 1 not cleared");

  chk_empty_clear2: assert property (@(posedge pclk) disable iff (!presetn)
    (sw_clear_empty[2] && !tx_event.done[2]) |=> !tx_empty_flag[2])
    else $error("empty flag 2 not cleared");

  // Acceptance control
  chk_idac_lock: assert property (@(posedge pclk) disable iff (!presetn)
    !init_mode |=> $stable(filter_mode))
    else $error("mode changed outside init");

  chk_idac_write: assert property (@(posedge pclk) disable iff (!presetn)
    (init_mode && wr && paddr == `CTS_OFF_IDAC) |=> filter_mode == $past(pwdata[5:4]))
    else $error("mode not written in init");

  chk_mode_decode: assert property (@(posedge pclk) disable iff (!presetn)
    rx_accept_enable == (acceptance_mode_field != `CTS_FMODE_CLOSED))
    else $error("closed mode decode wrong");

  chk_closed_nohit: assert property (@(posedge pclk) disable iff (!presetn)
    (filter_mode == 2'h3) |=> $stable(filter_hit_index))
    else $error("closed filter loaded");

  chk_hit_update: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_event.load && rx_accept_enable) |=> filter_hit_index == $past(rx_event.hit))
    else $error("hit not updated");

  chk_hit_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !rx_event.load |=> $stable(filter_hit_index))
    else $error("hit changed without load");

  chk_hit_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && paddr == `CTS_OFF_IDAC) |=> prdata[2:0] == $past(filter_hit_index))
    else $error("hit read wrong");

  chk_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && paddr == 12'h00c) |=> prdata == 32'h0)
    else $error("reserved nonzero");

  // Sticky interrupt status
  chk_int_abort: assert property (@(posedge pclk) disable iff (!presetn)
    (|tx_event.aborted) |=> int_stat[`CTS_INT_ABORT])
    else $error("abort status not set");

  chk_int_hit: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_event.load && rx_accept_enable) |=> int_stat[`CTS_INT_HIT])
    else $error("hit status not set");

  chk_int_block: assert property (@(posedge pclk) disable iff (!presetn)
    block_event |=> int_stat[`CTS_INT_BLOCK])
    else $error("block status not set");

  chk_int_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (int_clr[0] && !int_set[0]) |=> !int_stat[0])
    else $error("status not cleared");
endmodule

// ### logic/cts_pkg.sv
// Types shared by the tx-select/acceptance block.
// Assumes cts_regs.svh supplies the numeric constants.
package cts_pkg;
  typedef enum logic [1:0] {
    cts_two_32,
    cts_four_16,
    cts_eight_8,
    cts_closed
  } cts_mode_type;

  typedef struct packed {
    logic [2:0] done;
    logic [2:0] aborted;
  } cts_tx_event_type;

  typedef struct packed {
    logic       load;
    logic [2:0] hit;
  } cts_rx_event_type;
endpackage

// ### logic/cts_regs.svh
// Register offsets, field positions, reset values for the tx-select/acceptance block.
// Assumes byte addressing on a 32-bit APB, one register per aligned word.
`ifndef CTS_REGS_SVH
`define CTS_REGS_SVH
`define CTS_OFF_TAAK      12'h000
`define CTS_OFF_TBSEL     12'h004
`define CTS_OFF_IDAC      12'h008
`define CTS_OFF_RSVD0     12'h00c
`define CTS_OFF_RSVD1     12'h00d
`define CTS_OFF_RSVD_WORD 12'h00c
`define CTS_OFF_INT_STAT  12'h010
`define CTS_OFF_INT_EN    12'h014
`define CTS_OFF_INT_CLR   12'h018
`define CTS_OFF_MODE      12'h01c
`define CTS_OFF_WINDOW    12'h020
`define CTS_OFF_WINDOW_END 12'h040
`define CTS_NBUF          3
`define CTS_FMODE_LSB     4
`define CTS_FMODE_MSB     5
`define CTS_HIT_MSB       2
`define CTS_RESET_3       3'h0
`define CTS_RESET_FMODE   2'h0
`define CTS_FMODE_CLOSED  2'h3
`define CTS_INT_HIT       0
`define CTS_INT_ABORT     1
`define CTS_INT_BLOCK     2
`endif
